// File: rtl/cpu_ctl_subset.sv
// Behaviour
// RULE1: rc oscillator select switches main clock source
// RULE2: row pointer decrement, skip next when 15
// RULE3: mask op clears global interrupt allow flag
// RULE4: halt arm makes next restart stop watchdog
// RULE5: unmask op sets global interrupt allow flag
// RULE6: acceptance starts one machine cycle after unmask
// RULE7: power-down valid only right after arm
// RULE8: skipped slot is a no-operation
`timescale 1ns/1ps
module cpu_ctl_subset #(
   parameter logic [9:0] OP_IRQ_MASK   = 10'h004,
   parameter logic [9:0] OP_IRQ_UNMASK = 10'h005,
   parameter logic [9:0] OP_WDT_RST    = 10'h2a0,
   parameter logic [9:0] OP_PD         = 10'h002,
   parameter logic [9:0] OP_DEEP_PD    = 10'h008
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire cpu_ctl_pkg::instr_t   instr,
   input  wire cpu_ctl_pkg::row_load_t row_load,
   output cpu_ctl_pkg::ctl_out_t      ctl
);

   // overlapping codes would make one slot fire two decoders at once
   if (OP_IRQ_MASK == OP_IRQ_UNMASK || OP_PD == OP_DEEP_PD ||
       OP_IRQ_MASK == OP_WDT_RST || OP_IRQ_MASK == OP_PD ||
       OP_IRQ_MASK == OP_DEEP_PD || OP_IRQ_UNMASK == OP_WDT_RST ||
       OP_IRQ_UNMASK == OP_PD || OP_IRQ_UNMASK == OP_DEEP_PD ||
       OP_WDT_RST == OP_PD || OP_WDT_RST == OP_DEEP_PD ||
       OP_WDT_RST == cpu_ctl_pkg::OP_WDT_HALT_ARM ||
       OP_PD == cpu_ctl_pkg::OP_PD_ARM ||
       OP_DEEP_PD == cpu_ctl_pkg::OP_PD_ARM) begin : g_bad_codes
      $error("cpu_ctl_subset: opcode parameters overlap");
   end

   cpu_ctl_pkg::ctl_state_t st;
   cpu_ctl_pkg::ctl_state_t next_st;

   logic go;
   logic hit_rc;
   logic hit_dec;
   logic hit_mask;
   logic hit_unmask;
   logic hit_halt;
   logic hit_watchdog_restart_op;
   logic hit_arm;
   logic hit_pd;
   logic hit_dpd;
   logic [3:0] row_dec;

   // a slot flagged for skipping never decodes
   assign go         = instr.exec && !st.out.skip_next; // RULE8
   assign hit_rc     = go && instr.code == cpu_ctl_pkg::OP_SELECT_RC;
   assign hit_dec    = go && instr.code == cpu_ctl_pkg::OP_INDEX_DEC;
   assign hit_mask   = go && instr.code == OP_IRQ_MASK;
   assign hit_unmask = go && instr.code == OP_IRQ_UNMASK;
   assign hit_halt   = go && instr.code == cpu_ctl_pkg::OP_WDT_HALT_ARM;
   assign hit_watchdog_restart_op   = go && instr.code == OP_WDT_RST;
   assign hit_arm    = go && instr.code == cpu_ctl_pkg::OP_PD_ARM;
   assign hit_pd     = go && instr.code == OP_PD;
   assign hit_dpd    = go && instr.code == OP_DEEP_PD;
   assign row_dec    = st.out.row_ptr - cpu_ctl_pkg::ROW_STEP;

   always_comb begin
      next_st                 = st;
      next_st.out.wdt_restart = 1'b0;
      next_st.out.wdt_stop    = 1'b0;
      next_st.out.pd_req      = 1'b0;
      next_st.out.dpd_req     = 1'b0;
      next_st.out.skipped     = 1'b0;
      // an external load loses to a decrement in the same cycle
      if (row_load.load && !hit_dec) begin
         next_st.out.row_ptr = row_load.value;
      end
      if (instr.exec) begin
         // every slot, skipped or not, is one machine cycle
         if (st.ei_wait) begin
            next_st.ei_wait        = 1'b0;
            next_st.out.irq_accept = 1'b1; // RULE6
         end
         // the arm only covers the very next slot
         next_st.pd_armed = 1'b0; // RULE7
         if (st.out.skip_next) begin
            next_st.out.skip_next = 1'b0; // RULE8
            next_st.out.skipped   = 1'b1; // RULE8
         end
      end
      if (hit_rc) begin
         next_st.out.osc_rc = 1'b1; // RULE1
      end
      if (hit_dec) begin
         next_st.out.row_ptr   = row_dec; // RULE2
         next_st.out.skip_next = row_dec == cpu_ctl_pkg::ROW_SKIP_VALUE; // RULE2
      end
      if (hit_mask) begin
         next_st.out.irq_allow  = 1'b0; // RULE3
         next_st.out.irq_accept = 1'b0; // RULE3
         next_st.ei_wait        = 1'b0; // RULE3
      end
      if (hit_unmask) begin
         next_st.out.irq_allow = 1'b1; // RULE5
         next_st.ei_wait       = !st.out.irq_accept; // RULE6
      end
      if (hit_halt) begin
         next_st.wdt_armed = 1'b1; // RULE4
      end
      if (hit_watchdog_restart_op) begin
         next_st.out.wdt_restart = 1'b1;
         next_st.out.wdt_stop    = st.wdt_armed; // RULE4
         next_st.wdt_armed       = 1'b0; // RULE4
      end
      if (hit_arm) begin
         next_st.pd_armed = 1'b1; // RULE7
      end
      // unarmed power-down codes fall through as no-operations
      next_st.out.pd_req  = hit_pd && st.pd_armed; // RULE7
      next_st.out.dpd_req = hit_dpd && st.pd_armed; // RULE7
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st                <= '0;
         st.out.osc_rc     <= cpu_ctl_pkg::OSC_RC_RST;
         st.out.row_ptr    <= cpu_ctl_pkg::ROW_RST;
         st.out.irq_allow  <= cpu_ctl_pkg::IRQ_ALLOW_RST;
      end else begin
         st <= next_st;
      end
   end

   assign ctl = st.out;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_rc_select: assert property (hit_rc |=> ctl.osc_rc) // RULE1
      else $error("rc select did not switch clock source");
   a_dec_value: assert property (hit_dec |=>
      ctl.row_ptr == $past(row_dec)) // RULE2
      else $error("row pointer not decremented by one");
   a_dec_skip: assert property (hit_dec |=>
      ctl.skip_next == ($past(st.out.row_ptr) == 4'h0)) // RULE2
      else $error("skip flag wrong after decrement");
   a_skip_nop: assert property (instr.exec && st.out.skip_next
      && !row_load.load |=> ctl.skipped && $stable(ctl.row_ptr)
      && $stable(ctl.irq_allow) && $stable(ctl.osc_rc)
      && !ctl.pd_req && !ctl.wdt_restart) // RULE8
      else $error("skipped slot changed state");
   a_mask_clear: assert property (hit_mask |=>
      !ctl.irq_allow && !ctl.irq_accept) // RULE3
      else $error("mask op left interrupts allowed");
   a_unmask_set: assert property (hit_unmask && !ctl.irq_accept |=> // RULE5
      ctl.irq_allow && ctl.irq_accept == $past(st.ei_wait))
      else $error("unmask op wrong flag state");
   a_accept_delay: assert property (st.ei_wait && instr.exec
      && !hit_mask |=> ctl.irq_accept) // RULE6
      else $error("acceptance not enabled after one cycle");
   a_wdt_stop: assert property (hit_watchdog_restart_op && st.wdt_armed |=>
      ctl.wdt_stop && ctl.wdt_restart ##1 !ctl.wdt_stop) // RULE4
      else $error("armed restart did not stop watchdog");
   a_wdt_plain: assert property (hit_watchdog_restart_op && !st.wdt_armed |=>
      !ctl.wdt_stop && ctl.wdt_restart) // RULE4
      else $error("unarmed restart stopped watchdog");
   a_pd_gate: assert property ((ctl.pd_req || ctl.dpd_req) |->
      $past(st.pd_armed) && $past(hit_pd || hit_dpd)) // RULE7
      else $error("power-down accepted without arm");

   // only reset may hand the clock back to the other source
   a_osc_sticky: assert property (ctl.osc_rc |=> ctl.osc_rc) // RULE1
      else $error("rc clock source dropped");

   a_skip_origin: assert property ( // RULE2
      ctl.skip_next && !$past(ctl.skip_next) |-> $past(hit_dec))
      else $error("skip flag raised without decrement");

   a_accept_allow: assert property (ctl.irq_accept |-> // RULE6
      ctl.irq_allow)
      else $error("acceptance without allow flag");

   a_allow_hold: assert property (ctl.irq_allow && !hit_mask |=> // RULE5
      ctl.irq_allow)
      else $error("allow flag dropped without mask op");

   a_restart_src: assert property (ctl.wdt_restart |-> // RULE4
      $past(hit_watchdog_restart_op))
      else $error("restart pulse without restart op");

   a_stop_pair: assert property (ctl.wdt_stop |-> // RULE4
      ctl.wdt_restart)
      else $error("watchdog stop without restart");

   a_halt_persist: assert property (st.wdt_armed && !hit_watchdog_restart_op |=> // RULE4
      st.wdt_armed)
      else $error("watchdog stop arm lost early");

   a_pd_single: assert property (!(ctl.pd_req && ctl.dpd_req)) // RULE7
      else $error("both power-down requests at once");

   a_arm_expire: assert property ( // RULE7
      st.pd_armed && instr.exec && !hit_arm |=> !st.pd_armed)
      else $error("power-down arm outlived next slot");

   a_skip_clear: assert property (ctl.skip_next && instr.exec |=> // RULE8
      !ctl.skip_next && ctl.skipped)
      else $error("skip flag not consumed by next slot");

   c_dec_skip:  cover property (hit_dec ##1 ctl.skip_next ##[1:4]
      ctl.skipped);
   c_accept:    cover property (hit_unmask ##[1:4] ctl.irq_accept);
   c_wdt_stop:  cover property (hit_halt ##[1:4] ctl.wdt_stop);
   c_pd:        cover property (hit_arm ##[1:4] ctl.pd_req);
   c_dpd:       cover property (hit_arm ##[1:4] ctl.dpd_req);

endmodule

// File: rtl/cpu_ctl_pkg.sv
package cpu_ctl_pkg;

   localparam int          INSTR_W         = 10;
   localparam int          ROW_W           = 4;

   localparam logic [9:0]  OP_SELECT_RC    = 10'h29b;
   localparam logic [9:0]  OP_INDEX_DEC    = 10'h017;
   localparam logic [9:0]  OP_WDT_HALT_ARM = 10'h29c;
   localparam logic [9:0]  OP_PD_ARM       = 10'h05b;

   localparam logic [3:0]  ROW_SKIP_VALUE  = 4'hf;
   localparam logic [3:0]  ROW_RST         = 4'h0;
   localparam logic [3:0]  ROW_STEP        = 4'h1;
   localparam logic        OSC_RC_RST      = 1'b0;
   localparam logic        IRQ_ALLOW_RST   = 1'b0;

   typedef struct packed {
      logic [9:0] code;
      logic       exec;
   } instr_t;

   typedef struct packed {
      logic       load;
      logic [3:0] value;
   } row_load_t;

   typedef struct packed {
      logic       osc_rc;
      logic [3:0] row_ptr;
      logic       irq_allow;
      logic       irq_accept;
      logic       wdt_restart;
      logic       wdt_stop;
      logic       pd_req;
      logic       dpd_req;
      logic       skip_next;
      logic       skipped;
   } ctl_out_t;

   typedef struct packed {
      ctl_out_t   out;
      logic       ei_wait;
      logic       wdt_armed;
      logic       pd_armed;
   } ctl_state_t;

endpackage

// File: dv/tb_cpu_ctl_subset.sv
`timescale 1ns/1ps
module tb_cpu_ctl_subset;
   localparam logic [9:0] MSK = 10'h004;
   localparam logic [9:0] UNM = 10'h005;
   localparam logic [9:0] WRS = 10'h2a0;
   localparam logic [9:0] PD  = 10'h002;
   localparam logic [9:0] DPD = 10'h008;
   localparam logic [9:0] NOP = 10'h3ff;
   logic                   ref_clk;
   logic                   rst;
   cpu_ctl_pkg::instr_t    instr;
   cpu_ctl_pkg::row_load_t row_load;
   cpu_ctl_pkg::ctl_out_t  ctl;
   int                     fails = 0;
   int                     num_checks = 0;
   int                     cyc = 0;
   cpu_ctl_subset #(.OP_IRQ_MASK(MSK), .OP_IRQ_UNMASK(UNM),
      .OP_WDT_RST(WRS), .OP_PD(PD), .OP_DEEP_PD(DPD)) cpu_ctl_subset_i (
      .ref_clk (ref_clk),
      .rst     (rst),
      .instr   (instr),
      .row_load(row_load),
      .ctl     (ctl));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task summarize;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ceiling well above the few dozen cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         summarize;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // a later row_load assignment in the same step overrides this release
   task op(input logic [9:0] c);
      @(posedge ref_clk);
      instr <= '{code: c, exec: 1'b1};
      row_load.load <= 1'b0;
   endtask
   task fin;
      @(posedge ref_clk);
      instr <= '{code: NOP, exec: 1'b0};
      #1;
   endtask
   task t_dec(input logic [3:0] v);
      op(MSK);
      row_load <= '{load: 1'b1, value: v};
      op(cpu_ctl_pkg::OP_INDEX_DEC);
      op(UNM);
      #1;
      chk(ctl.skip_next, v == 4'h0);
      fin;
      chk(ctl.row_ptr, 4'(v - 4'h1));
      chk(ctl.skipped, v == 4'h0);
      chk(ctl.irq_allow, v != 4'h0);
      chk(ctl.irq_accept, 0);
      op(NOP);
      fin;
      chk({ctl.irq_allow, ctl.irq_accept}, {2{v != 4'h0}});
      op(MSK);
      fin;
      chk({ctl.irq_allow, ctl.irq_accept}, 0);
      $display("dec test %h done", v);
   endtask
   task t_pd(input bit arm, gap, input logic [9:0] c, input bit p, d);
      if (arm) op(cpu_ctl_pkg::OP_PD_ARM);
      if (gap) op(NOP);
      op(c);
      fin;
      chk({ctl.pd_req, ctl.dpd_req}, {p, d});
      $display("power-down test done");
   endtask
   task t_wdt;
      op(WRS);
      fin;
      chk({ctl.wdt_restart, ctl.wdt_stop}, 2'b10);
      op(cpu_ctl_pkg::OP_WDT_HALT_ARM);
      op(NOP);
      op(WRS);
      fin;
      chk({ctl.wdt_restart, ctl.wdt_stop}, 2'b11);
      op(WRS);
      fin;
      chk({ctl.wdt_restart, ctl.wdt_stop}, 2'b10);
      $display("watchdog test done");
   endtask
   initial begin
      rst = 1'b1;
      instr = '{code: NOP, exec: 1'b0};
      row_load = '0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk(ctl, 0);
      op(cpu_ctl_pkg::OP_SELECT_RC);
      fin;
      chk(ctl.osc_rc, 1);
      $display("rc select test done");
      t_dec(4'h0);
      t_dec(4'h5);
      t_wdt;
      t_pd(0, 0, PD, 0, 0);
      t_pd(1, 0, PD, 1, 0);
      t_pd(1, 1, DPD, 0, 0);
      t_pd(1, 0, DPD, 0, 1);
      summarize;
   end
endmodule
